// ---- common/slot_switch_map.svh ----
`ifndef SLOT_SWITCH_MAP_SVH
`define SLOT_SWITCH_MAP_SVH

// ==================================================================
// Frame geometry
`define SLOT_W 5
`define SLOTS 32

// ==================================================================
// Memory operation codes written to the control register
`define MOC_CM_FULL_HI 4'h7
`define MOC_CM_PTR 8'h48
`define MOC_TRISTATE 8'h60

// ==================================================================
// Switching codes held in the connection memory
`define CODE_64K 4'h1
`define CODE_16K_B10 4'h4
`define CODE_16K_B32 4'h6
`define CODE_16K_B76 4'h7
`define CODE_32K_B74 4'h3

// ==================================================================
// Per-port subchannel selection values
`define SEL_MODE3 2'b11
`define SEL_MODE2 2'b10
`define SEL_MODE1 2'b01
`define SEL_MODE0 2'b00
`define SUBCHAN_RST 8'h00

// ==================================================================
// Field positions and write masks
`define ADDR_DIR_BIT 7
`define PTR_DIR_BIT 7
`define CM_W 12
`define CM_MASK_FULL 12'hfff
`define CM_MASK_PTR 12'hff0
`define TS_W 4

`endif

// ---- common/slot_switch_pkg.sv ----
package slot_switch_pkg;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_CM = 2'b01,
    CMD_PTR = 2'b10,
    CMD_TS = 2'b11
  } cmd_e;

  typedef enum logic {
    H_IDLE = 1'b0,
    H_WAIT = 1'b1
  } host_state_e;

  typedef logic [7:0] byte_t;

endpackage : slot_switch_pkg

// ---- core/slot_ram.sv ----
`timescale 1ns/1ps
`include "slot_switch_map.svh"

module slot_ram #(
  parameter int W = 8
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  // Bit-masked write port
  input wire logic we,
  input wire logic [`SLOT_W-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] wmask,
  // Two registered read ports
  input wire logic [`SLOT_W-1:0] ra,
  input wire logic [`SLOT_W-1:0] rb,
  output logic [W-1:0] qa,
  output logic [W-1:0] qb
);

  logic [W-1:0] mem [`SLOTS];

  // Read during write returns the old word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < `SLOTS; i++) begin
        mem[i] <= '0;
      end
      qa <= '0;
      qb <= '0;
    end else if (en) begin
      if (we) begin
        mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
      end
      qa <= mem[ra];
      qb <= mem[rb];
    end
  end

endmodule : slot_ram

// ---- core/slot_switch.sv ----
`timescale 1ns/1ps
`include "slot_switch_map.svh"

module slot_switch
  import slot_switch_pkg::*;
(
  // System clock domain
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Host register writes
  input wire slot_switch_pkg::byte_t wdata,
  input wire logic data_reg_wr,
  input wire logic addr_reg_wr,
  input wire logic ctrl_reg_wr,
  input wire logic subchan_wr,
  // Host status
  output logic busy,
  output slot_switch_pkg::byte_t line_subchannel_select_reg,
  // Link domain
  input wire logic link_clk,
  input wire logic link_fs,
  input wire slot_switch_pkg::byte_t pcm_rx,
  input wire slot_switch_pkg::byte_t line_rx,
  output slot_switch_pkg::byte_t pcm_tx,
  output slot_switch_pkg::byte_t pcm_tx_oe,
  output slot_switch_pkg::byte_t line_tx,
  output slot_switch_pkg::byte_t line_tx_oe
);
  import slot_switch_pkg::*;

  // ================================================================
  // Decoding shared by both directions, except line_mask which serves downstream only

  function automatic byte_t pcm_mask(input logic [3:0] code);
    case (code)
      `CODE_64K: pcm_mask = 8'hff;
      `CODE_16K_B10: pcm_mask = 8'h03;
      `CODE_16K_B32: pcm_mask = 8'h0c;
      `CODE_16K_B76: pcm_mask = 8'hc0;
      `CODE_32K_B74: pcm_mask = 8'hf0;
      default: pcm_mask = 8'h00;
    endcase
  endfunction : pcm_mask

  function automatic logic [2:0] pcm_pos(input logic [3:0] code);
    case (code)
      `CODE_16K_B32: pcm_pos = 3'h2;
      `CODE_16K_B76: pcm_pos = 3'h6;
      `CODE_32K_B74: pcm_pos = 3'h4;
      default: pcm_pos = 3'h0;
    endcase
  endfunction : pcm_pos

  function automatic byte_t line_mask(input logic [1:0] sel, input logic [3:0] code);
    logic wide;
    wide = (code == `CODE_32K_B74);
    if (code == `CODE_64K) begin
      line_mask = 8'hff;
    end else begin
      case (sel)
        `SEL_MODE3: line_mask = wide ? 8'h0f : 8'h03;
        `SEL_MODE2: line_mask = wide ? 8'hf0 : 8'h0c;
        `SEL_MODE1: line_mask = wide ? 8'h0f : 8'h30;
        default: line_mask = wide ? 8'hf0 : 8'hc0;
      endcase
    end
  endfunction : line_mask

  function automatic logic [2:0] line_pos(input logic [1:0] sel, input logic [3:0] code);
    logic wide;
    wide = (code == `CODE_32K_B74);
    if (code == `CODE_64K) begin
      line_pos = 3'h0;
    end else begin
      case (sel)
        `SEL_MODE3: line_pos = 3'h0;
        `SEL_MODE2: line_pos = wide ? 3'h4 : 3'h2;
        `SEL_MODE1: line_pos = wide ? 3'h0 : 3'h4;
        default: line_pos = wide ? 3'h4 : 3'h6;
      endcase
    end
  endfunction : line_pos

  // ================================================================
  // Host side registers (system clock)
  byte_t mdata_ff;
  byte_t maddr_ff;
  logic [3:0] mcode_ff;
  cmd_e cmd_ff;
  host_state_e state_ff;
  logic busy_ff;
  logic req_tgl_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  byte_t subchan_ff;
  cmd_e nxt_cmd;
  logic ack_tgl_ff;

  // Registers are frozen while a command is in flight
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdata_ff <= 8'h00;
      maddr_ff <= 8'h00;
    end else if (ce && state_ff == H_IDLE) begin
      if (data_reg_wr) begin
        mdata_ff <= wdata;
      end
      if (addr_reg_wr) begin
        maddr_ff <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      subchan_ff <= `SUBCHAN_RST;
    end else if (ce && subchan_wr) begin
      subchan_ff <= wdata;
    end
  end

  always_comb begin
    nxt_cmd = CMD_NONE;
    if (wdata[7:4] == `MOC_CM_FULL_HI) begin
      nxt_cmd = CMD_CM;
    end else if (wdata == `MOC_CM_PTR) begin
      nxt_cmd = CMD_PTR;
    end else if (wdata == `MOC_TRISTATE) begin
      nxt_cmd = CMD_TS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else if (ce) begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // Toggle handshake; command fields stay still until the ack returns
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= H_IDLE;
      busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      cmd_ff <= CMD_NONE;
      mcode_ff <= 4'h0;
    end else if (ce) begin
      unique case (state_ff)
        H_IDLE: begin
          if (ctrl_reg_wr && nxt_cmd != CMD_NONE) begin
            cmd_ff <= nxt_cmd;
            mcode_ff <= wdata[3:0];
            req_tgl_ff <= ~req_tgl_ff;
            state_ff <= H_WAIT;
            busy_ff <= 1'b1;
          end
        end
        H_WAIT: begin
          if (ack_s2_ff == req_tgl_ff) begin
            state_ff <= H_IDLE;
            busy_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  assign busy = busy_ff;
  assign line_subchannel_select_reg = subchan_ff;

  // ================================================================
  // Crossings into the link domain
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic lce_s1_ff;
  logic lce_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  byte_t sel_s1_ff;
  byte_t sel_s2_ff;
  byte_t sel_s3_ff;
  byte_t sel_use_ff;
  logic run;
  logic hw;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= rst_b;
    lrst_s2_ff <= lrst_s1_ff;
    lce_s1_ff <= ce;
    lce_s2_ff <= lce_s1_ff;
    req_s1_ff <= req_tgl_ff;
    req_s2_ff <= req_s1_ff;
    sel_s1_ff <= subchan_ff;
    sel_s2_ff <= sel_s1_ff;
    sel_s3_ff <= sel_s2_ff;
  end

  assign run = lce_s2_ff;
  assign hw = run && (req_s2_ff ^ req_s3_ff);

  // A byte caught mid-change lasts one cycle; take it only once seen twice
  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      sel_use_ff <= `SUBCHAN_RST;
    end else if (run && sel_s2_ff == sel_s3_ff) begin
      sel_use_ff <= sel_s2_ff;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      req_s3_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
    end else if (run) begin
      req_s3_ff <= req_s2_ff;
      if (hw) begin
        ack_tgl_ff <= req_s2_ff;
      end
    end
  end

  // ================================================================
  // Frame engine (link clock)
  logic [`SLOT_W-1:0] cur_slot;
  logic [`SLOT_W-1:0] slot_ff;
  logic [`SLOT_W-1:0] s1_slot_ff;
  logic [`SLOT_W-1:0] s2_slot_ff;
  byte_t s1_line_ff;
  logic [3:0] s2_code_ff;
  logic s2_dir_ff;
  logic [`CM_W-1:0] up_cm_q;
  logic [`CM_W-1:0] dn_cm_q;
  logic [`TS_W-1:0] ts_q;
  byte_t up_dm_qa;
  byte_t up_dm_qb;
  byte_t dn_dm_qb;
  logic cm_up_we;
  logic cm_dn_we;
  logic [`CM_W-1:0] cm_mask;
  logic [3:0] up_code;
  logic [1:0] up_sel;
  logic [1:0] dn_sel;
  byte_t up_tmp;
  byte_t up_data;
  byte_t up_mask;
  byte_t dn_src;
  byte_t dn_tmp;
  byte_t nxt_line_oe;
  byte_t pcm_tx_ff;
  byte_t pcm_oe_ff;
  byte_t line_tx_ff;
  byte_t line_oe_ff;

  assign cur_slot = link_fs ? '0 : slot_ff;

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      slot_ff <= '0;
      s1_slot_ff <= '0;
      s1_line_ff <= 8'h00;
      s2_slot_ff <= '0;
      s2_code_ff <= 4'h0;
      s2_dir_ff <= 1'b0;
    end else if (run) begin
      slot_ff <= cur_slot + 1'b1;
      s1_slot_ff <= cur_slot;
      s1_line_ff <= line_rx;
      s2_slot_ff <= s1_slot_ff;
      s2_code_ff <= dn_cm_q[3:0];
      s2_dir_ff <= dn_cm_q[4 + `PTR_DIR_BIT];
    end
  end

  // host writes land only in memories
  assign cm_up_we = hw && (cmd_ff == CMD_CM || cmd_ff == CMD_PTR) && maddr_ff[`ADDR_DIR_BIT];
  assign cm_dn_we = hw && (cmd_ff == CMD_CM || cmd_ff == CMD_PTR) && !maddr_ff[`ADDR_DIR_BIT];
  assign cm_mask = (cmd_ff == CMD_PTR) ? `CM_MASK_PTR : `CM_MASK_FULL;

  slot_ram #(.W(`CM_W)) u_up_cm (
    .clk(link_clk), .rst_b(lrst_s2_ff), .en(run),
    .we(cm_up_we), .waddr(maddr_ff[`SLOT_W-1:0]),
    .wdata({mdata_ff, mcode_ff}), .wmask(cm_mask),
    .ra(cur_slot), .rb(cur_slot), .qa(up_cm_q), .qb()
  );

  slot_ram #(.W(`CM_W)) u_dn_cm (
    .clk(link_clk), .rst_b(lrst_s2_ff), .en(run),
    .we(cm_dn_we), .waddr(maddr_ff[`SLOT_W-1:0]),
    .wdata({mdata_ff, mcode_ff}), .wmask(cm_mask),
    .ra(cur_slot), .rb(cur_slot), .qa(dn_cm_q), .qb()
  );

  slot_ram #(.W(`TS_W)) u_ts (
    .clk(link_clk), .rst_b(lrst_s2_ff), .en(run),
    .we(hw && cmd_ff == CMD_TS), .waddr(maddr_ff[`SLOT_W-1:0]),
    .wdata(mdata_ff[`TS_W-1:0]), .wmask({`TS_W{1'b1}}),
    .ra(cur_slot), .rb(cur_slot), .qa(ts_q), .qb()
  );

  assign up_code = up_cm_q[3:0];
  assign up_sel = sel_use_ff[2 * s1_slot_ff[4:3] +: 2];
  assign dn_sel = sel_use_ff[2 * s2_slot_ff[4:3] +: 2];

  // one line sub-slot mapped into a PCM part
  always_comb begin
    up_tmp = s1_line_ff >> line_pos(up_sel, up_code);
    up_mask = pcm_mask(up_code);
    up_data = (up_tmp << pcm_pos(up_code)) & up_mask;
  end

  // line loop data parks in upstream sample memory
  slot_ram #(.W(8)) u_up_dm (
    .clk(link_clk), .rst_b(lrst_s2_ff), .en(run),
    .we(up_mask != 8'h00), .waddr(up_cm_q[4 +: `SLOT_W]),
    .wdata(up_data), .wmask(up_mask),
    .ra(cur_slot), .rb(dn_cm_q[4 +: `SLOT_W]), .qa(up_dm_qa), .qb(up_dm_qb)
  );

  slot_ram #(.W(8)) u_dn_dm (
    .clk(link_clk), .rst_b(lrst_s2_ff), .en(run),
    .we(1'b1), .waddr(cur_slot), .wdata(pcm_rx), .wmask(8'hff),
    .ra(cur_slot), .rb(dn_cm_q[4 +: `SLOT_W]), .qa(), .qb(dn_dm_qb)
  );

  // same pointer serves both loop halves
  always_comb begin
    dn_src = s2_dir_ff ? up_dm_qb : dn_dm_qb;
    dn_tmp = dn_src >> pcm_pos(s2_code_ff);
    // Unassigned codes still map to a position, so the enable must gate data
    nxt_line_oe = (pcm_mask(s2_code_ff) != 8'h00) ? line_mask(dn_sel, s2_code_ff) : 8'h00;
  end

  // ================================================================
  // Output stage
  wire [7:0] nxt_pcm_oe;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pair
      assign nxt_pcm_oe[2*g +: 2] = {2{ts_q[g]}};
    end
  endgenerate

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      pcm_oe_ff <= 8'h00;
    end else if (run) begin
      pcm_oe_ff <= nxt_pcm_oe;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      pcm_tx_ff <= 8'h00;
    end else if (run) begin
      pcm_tx_ff <= up_dm_qa;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      line_tx_ff <= 8'h00;
      line_oe_ff <= 8'h00;
    end else if (run) begin
      line_oe_ff <= nxt_line_oe;
      line_tx_ff <= (dn_tmp << line_pos(dn_sel, s2_code_ff)) & nxt_line_oe;
    end
  end

  assign pcm_tx = pcm_tx_ff;
  assign pcm_tx_oe = pcm_oe_ff;
  assign line_tx = line_tx_ff;
  assign line_tx_oe = line_oe_ff;

endmodule : slot_switch

// ---- verif/slot_highway_model.sv ----
`timescale 1ns/1ps

module slot_highway_model (
  // Link clock from the bench
  input wire logic link_clk,
  // Frame marker and slot data toward the switch
  output logic link_fs,
  output slot_switch_pkg::byte_t pcm_rx,
  output slot_switch_pkg::byte_t line_rx,
  output logic [4:0] cur_slot
);
  import slot_switch_pkg::*;

  // ==================================================================
  // Slot data patterns, nibbles differ between slots
  function automatic byte_t pcm_val(input logic [4:0] s);
    return {s, s[4:2]} ^ 8'h3c;
  endfunction : pcm_val

  function automatic byte_t line_val(input logic [4:0] s);
    return {s[1:0], s, 1'b1} ^ 8'ha9;
  endfunction : line_val

  // ==================================================================
  // Frame of 32 slots, marker with slot 0
  initial begin
    cur_slot = 5'h1f;
    link_fs = 1'b0;
    pcm_rx = 8'h00;
    line_rx = 8'h00;
  end

  always @(posedge link_clk) begin
    #1;
    cur_slot = cur_slot + 5'h01;
    link_fs = (cur_slot == 5'h00);
    pcm_rx = pcm_val(cur_slot);
    line_rx = line_val(cur_slot);
  end
endmodule : slot_highway_model

// ---- verif/slot_switch_asserts.sv ----
`timescale 1ns/1ps
`include "slot_switch_map.svh"

module slot_switch_asserts (
  // System side
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire slot_switch_pkg::byte_t wdata,
  input wire logic ctrl_reg_wr,
  input wire logic subchan_wr,
  input wire logic busy,
  input wire slot_switch_pkg::byte_t line_subchannel_select_reg,
  // Link side
  input wire logic link_clk,
  input wire slot_switch_pkg::byte_t pcm_tx_oe,
  input wire slot_switch_pkg::byte_t line_tx,
  input wire slot_switch_pkg::byte_t line_tx_oe
);
  import slot_switch_pkg::*;

  logic moc_ok;
  assign moc_ok = (wdata[7:4] == `MOC_CM_FULL_HI) || (wdata == `MOC_CM_PTR) ||
    (wdata == `MOC_TRISTATE);

  // Link outputs are only defined once the link side has seen reset
  logic [2:0] lrst_q = 3'b000;
  always @(posedge link_clk) begin
    lrst_q <= {lrst_q[1:0], rst_b};
  end

  // ==================================================================
  // Host command handshake
  sequence take_s;
    ce && !busy && ctrl_reg_wr;
  endsequence

  sequence start_s;
    $rose(busy);
  endsequence

  cmd_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    take_s ##0 moc_ok |=> busy) else $error("Accepted command left busy low");
  cmd_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    take_s ##0 !moc_ok |=> !busy) else $error("Unknown command raised busy");
  // Crossing needs several link edges
  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    start_s |-> busy [*8]) else $error("Busy dropped too early");
  busy_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    start_s |-> ##[1:300] !busy) else $error("Busy never fell");

  // ==================================================================
  // Subchannel selection register
  sel_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    subchan_wr && ce |=> line_subchannel_select_reg == $past(wdata))
    else $error("Selection register not loaded");
  sel_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    !subchan_wr |=> $stable(line_subchannel_select_reg))
    else $error("Selection register changed unasked");

  // ==================================================================
  // Output enables
  line_slot_a: assert property (@(posedge link_clk) disable iff (!rst_b || !lrst_q[2])
    line_tx_oe inside {8'h00, 8'h03, 8'h0c, 8'h30, 8'hc0, 8'h0f, 8'hf0, 8'hff})
    else $error("Line enable is not one sub-slot");
  line_quiet_a: assert property (@(posedge link_clk) disable iff (!rst_b || !lrst_q[2])
    (line_tx & ~line_tx_oe) == 8'h00) else $error("Undriven line bit not zero");
  pcm_pair_a: assert property (@(posedge link_clk) disable iff (!rst_b || !lrst_q[2])
    (pcm_tx_oe & 8'h55) == ((pcm_tx_oe >> 1) & 8'h55))
    else $error("PCM enable splits a bit pair");
endmodule : slot_switch_asserts

bind slot_switch slot_switch_asserts chk_u (.clk(clk), .rst_b(rst_b), .ce(ce),
  .wdata(wdata), .ctrl_reg_wr(ctrl_reg_wr), .subchan_wr(subchan_wr), .busy(busy),
  .line_subchannel_select_reg(line_subchannel_select_reg), .link_clk(link_clk),
  .pcm_tx_oe(pcm_tx_oe), .line_tx(line_tx), .line_tx_oe(line_tx_oe));

// ---- verif/tdm_subchannel_switch_loops_bench.sv ----
`timescale 1ns/1ps
`include "slot_switch_map.svh"

`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module tdm_subchannel_switch_loops_bench;
  import slot_switch_pkg::*;
  logic clk, rst_b, ce, data_reg_wr, addr_reg_wr, ctrl_reg_wr, subchan_wr, busy;
  logic link_clk, link_fs;
  byte_t wdata, sel, pcm_rx, line_rx, pcm_tx, pcm_tx_oe, line_tx, line_tx_oe;
  logic [4:0] cur_slot;
  int error_cnt, n_tests, cycles;

  // ==================================================================
  // Clocks, link clock unrelated in phase
  initial clk = 1'b0;
  always #2 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #11.3;
    forever #32 link_clk = ~link_clk;
  end

  slot_switch dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .wdata(wdata),
    .data_reg_wr(data_reg_wr), .addr_reg_wr(addr_reg_wr), .ctrl_reg_wr(ctrl_reg_wr),
    .subchan_wr(subchan_wr), .busy(busy), .line_subchannel_select_reg(sel),
    .link_clk(link_clk), .link_fs(link_fs), .pcm_rx(pcm_rx), .line_rx(line_rx),
    .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe), .line_tx(line_tx), .line_tx_oe(line_tx_oe));

  slot_highway_model partner_u (.link_clk(link_clk), .link_fs(link_fs), .pcm_rx(pcm_rx),
    .line_rx(line_rx), .cur_slot(cur_slot));

  function automatic byte_t pv(input logic [4:0] s);
    return partner_u.pcm_val(s);
  endfunction : pv

  function automatic byte_t lv(input logic [4:0] s);
    return partner_u.line_val(s);
  endfunction : lv

  // ==================================================================
  // Verdict and hang guard
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      $display("Error at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // ==================================================================
  // Host access: data (optional), address, control; pk pokes data while busy
  task automatic cmd(input byte_t d, input byte_t a, input byte_t c, input bit wd,
                     input bit pk);
    int n;
    if (wd) begin
      wdata = d;
      data_reg_wr = 1'b1;
      @(posedge clk);
      #1 data_reg_wr = 1'b0;
    end
    wdata = a;
    addr_reg_wr = 1'b1;
    @(posedge clk);
    #1 addr_reg_wr = 1'b0;
    wdata = c;
    ctrl_reg_wr = 1'b1;
    @(posedge clk);
    #1 ctrl_reg_wr = 1'b0;
    `CHK(busy, 1'b1)
    if (pk) begin
      wdata = ~d;
      data_reg_wr = 1'b1;
      @(posedge clk);
      #1 data_reg_wr = 1'b0;
    end
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(busy, 1'b0)
  endtask : cmd

  // Output of slot s shows 2 (PCM) or 3 (line) link cycles later
  task automatic lchk(input bit pcm, input logic [4:0] s, input byte_t ed, input byte_t eo);
    int n;
    n = 0;
    do begin
      @(negedge link_clk);
      n++;
    end while (cur_slot !== s + (pcm ? 5'd2 : 5'd3) && n < 40);
    if (pcm) begin
      `CHK(pcm_tx & pcm_tx_oe, ed)
      `CHK(pcm_tx_oe, eo)
    end else begin
      `CHK(line_tx, ed)
      `CHK(line_tx_oe, eo)
    end
    @(posedge clk);
    #1;
  endtask : lchk

  // Upstream data needs a full frame to reach the outputs
  task automatic frames;
    repeat (64) @(posedge link_clk);
    @(posedge clk);
    #1;
  endtask : frames

  // ==================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    wdata = 8'h00;
    {data_reg_wr, addr_reg_wr, ctrl_reg_wr, subchan_wr} = 4'h0;
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    // Long enough for the link side synchroniser
    repeat (52) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK(sel, `SUBCHAN_RST)
    repeat (64) @(posedge clk);
    #1 wdata = 8'h93;
    subchan_wr = 1'b1;
    @(posedge clk);
    #1 subchan_wr = 1'b0;
    `CHK(sel, 8'h93)
    // Clock enable low: neither strobe may take effect
    ce = 1'b0;
    wdata = 8'h74;
    {ctrl_reg_wr, subchan_wr} = 2'b11;
    @(posedge clk);
    #1 {ctrl_reg_wr, subchan_wr} = 2'b00;
    ce = 1'b1;
    `CHK(sel, 8'h93)
    `CHK(busy, 1'b0)
    @(posedge clk);
    #1 wdata = 8'h50;
    ctrl_reg_wr = 1'b1;
    @(posedge clk);
    #1 ctrl_reg_wr = 1'b0;
    `CHK(busy, 1'b0)
    cmd(8'h84, 8'h83, 8'h74, 1, 0);
    cmd(8'h84, 8'h9f, 8'h76, 1, 0);
    cmd(8'h05, 8'h04, `MOC_TRISTATE, 1, 0);
    cmd(8'h0b, 8'h17, 8'h73, 1, 0);
    cmd(8'h04, 8'h15, 8'h77, 1, 0);
    cmd(8'h02, 8'h08, 8'h74, 1, 0);
    cmd(8'h06, 8'h01, 8'h73, 1, 0);
    cmd(8'h07, 8'h18, 8'h73, 1, 0);
    cmd(8'h08, 8'h19, 8'h76, 1, 0);
    cmd(8'h94, 8'h8a, 8'h71, 1, 0);
    cmd(8'h94, 8'h0d, 8'h71, 1, 0);
    frames();
    lchk(1, 5'd4, lv(5'd3) & 8'h03, 8'h33);
    lchk(1, 5'd20, 8'h00, 8'h00);
    lchk(0, 5'd23, pv(5'd11) >> 4, 8'h0f);
    lchk(0, 5'd21, (pv(5'd4) >> 2) & 8'h30, 8'h30);
    lchk(0, 5'd8, pv(5'd2) << 6, 8'hc0);
    lchk(0, 5'd1, pv(5'd6) >> 4, 8'h0f);
    lchk(0, 5'd24, pv(5'd7) & 8'hf0, 8'hf0);
    lchk(0, 5'd25, pv(5'd8) & 8'h0c, 8'h0c);
    lchk(0, 5'd13, lv(5'd10), 8'hff);
    lchk(0, 5'd30, 8'h00, 8'h00);
    cmd(8'h0f, 8'h14, `MOC_TRISTATE, 1, 1);
    cmd(8'h00, 8'h04, `MOC_TRISTATE, 0, 0);
    cmd(8'h09, 8'h19, `MOC_CM_PTR, 1, 0);
    frames();
    lchk(1, 5'd20, lv(5'd10), 8'hff);
    lchk(1, 5'd4, (lv(5'd3) & 8'h03) | (lv(5'd31) & 8'h0c), 8'hff);
    lchk(0, 5'd25, pv(5'd9) & 8'h0c, 8'h0c);
    report_and_stop();
  end
endmodule : tdm_subchannel_switch_loops_bench
